// ---- design/asc_core.v ----
// Asynchronous serial transmitter and receiver core.
//
// Strobed register access and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
`include "asc_regs.vh"
module asc_core #(
  parameter DIVW = 8
) (
  // Clock and reset
  input  wire       core_clk,
  input  wire       rst_n,
  // Register port
  input  wire [2:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_wr,
  input  wire       reg_rd,
  output reg  [7:0] reg_rdata,
  // Serial pins
  input  wire       serial_in_pin,
  output reg        serial_out_pin,
  output reg        serial_out_oe,
  // Interrupt requests
  output reg        tx_irq,
  output reg        rx_irq
);

  // ---------------------------------------------------------------
  // Functions
  // ---------------------------------------------------------------
  function maj3;
    input [2:0] s;
    begin
      maj3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
    end
  endfunction

  function [3:0] char_bits;
    input nine;
    begin
      char_bits = nine ? 4'hb : 4'ha;
    end
  endfunction

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  reg [7:0] ctrl1_r;
  reg [7:0] ctrl2_r;
  reg       tx9_r;
  reg       rx9_r;
  reg [7:0] baud_r;
  reg [7:0] tdata_r;
  reg [7:0] rdata_r;
  reg       te_flag_r;
  reg       tc_flag_r;
  reg       rf_flag_r;
  reg       or_flag_r;
  reg       nf_flag_r;
  reg       fe_flag_r;
  reg       pe_flag_r;
  reg       bk_flag_r;
  reg       rp_flag_r;
  reg       stat1_seen_r;

  wire en     = ctrl1_r[`C1_ENABLE];
  wire nine   = ctrl1_r[`C1_NINE];
  wire par_en = ctrl1_r[`C1_PAR_EN];
  wire tx_en  = ctrl2_r[`C2_TX_EN];
  wire rx_en  = ctrl2_r[`C2_RX_EN];
  wire brk    = ctrl2_r[`C2_BREAK];

  // ---------------------------------------------------------------
  // Sample clock divider
  // ---------------------------------------------------------------
  reg [DIVW-1:0] div_r;
  wire           rt_tick = (div_r == {DIVW{1'b0}});

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_r <= {DIVW{1'b0}};
    end else if (!en || rt_tick) begin
      div_r <= baud_r[DIVW-1:0];
    end else begin
      div_r <= div_r - {{(DIVW-1){1'b0}}, 1'b1};
    end
  end

  // ---------------------------------------------------------------
  // Transmitter
  // ---------------------------------------------------------------
  localparam TX_IDLE = 3'b001;
  localparam TX_PRE  = 3'b010;
  localparam TX_SHFT = 3'b100;

  reg [2:0]  tx_st_r;
  reg [10:0] tx_sh_r;
  reg [3:0]  tx_cnt_r;
  reg [3:0]  tx_rt_r;
  reg        tx_brk_r;
  reg        tx_post_r;
  reg        tx_qidle_r;
  reg        tx_line_r;

  wire bit_end = rt_tick && (tx_rt_r == `ASC_RT_LAST);
  wire last    = (tx_cnt_r == 4'h1);
  wire tpar    = ^{tdata_r, nine & tx9_r} ^ ctrl1_r[`C1_PAR_ODD];
  wire wr_data = reg_wr && (reg_addr == `ASC_DATA);
  wire wr_c2   = reg_wr && (reg_addr == `ASC_CTRL2);
  wire [10:0] frame8 = {1'b1, par_en ? tpar : tdata_r[7], tdata_r[6:0],
                        1'b0, 1'b0};
  wire [10:0] frame9 = {1'b1, par_en ? tpar : tx9_r, tdata_r, 1'b0};

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_st_r    <= TX_IDLE;
      tx_sh_r    <= 11'h7ff;
      tx_cnt_r   <= 4'h0;
      tx_rt_r    <= 4'h0;
      tx_brk_r   <= 1'b0;
      tx_post_r  <= 1'b0;
      tx_qidle_r <= 1'b0;
      tx_line_r  <= 1'b1;
    end else if (!en) begin
      tx_st_r    <= TX_IDLE;
      tx_cnt_r   <= 4'h0;
      tx_line_r  <= 1'b1;
      tx_qidle_r <= 1'b0;
    end else begin
      if (wr_c2 && tx_en && !reg_wdata[`C2_TX_EN] && tx_st_r == TX_SHFT)
        tx_qidle_r <= 1'b1;
      if (rt_tick)
        tx_rt_r <= tx_rt_r + 4'h1;
      case (tx_st_r)
        TX_IDLE: begin
          tx_line_r <= 1'b1;
          if (tx_en && (!te_flag_r || brk)) begin
            tx_st_r  <= TX_PRE;
            tx_cnt_r <= char_bits(nine) - (nine ? 4'h0 : 4'h0);
            tx_rt_r  <= 4'h0;
          end
        end
        TX_PRE: begin
          tx_line_r <= 1'b1;
          if (bit_end) begin
            tx_cnt_r <= tx_cnt_r - 4'h1;
            if (last) begin
              tx_st_r  <= TX_SHFT;
              tx_cnt_r <= char_bits(nine);
              tx_brk_r <= brk;
              if (brk)
                tx_sh_r <= 11'h000;
              else if (tx_en && !te_flag_r)
                tx_sh_r <= nine ? frame9 : {1'b1, frame8[10:1]};
              else
                tx_st_r <= TX_IDLE;
            end
          end
        end
        TX_SHFT: begin
          tx_line_r <= tx_sh_r[0];
          if (bit_end) begin
            tx_sh_r  <= {1'b1, tx_sh_r[10:1]};
            tx_cnt_r <= tx_cnt_r - 4'h1;
            if (last) begin
              if (tx_brk_r && !brk) begin
                tx_post_r <= 1'b1;
                tx_st_r   <= TX_PRE;
                tx_cnt_r  <= 4'h1;
              end else if (tx_qidle_r && tx_en) begin
                tx_qidle_r <= 1'b0;
                tx_st_r    <= TX_PRE;
                tx_cnt_r   <= char_bits(nine);
              end else if (tx_en && brk) begin
                tx_sh_r  <= 11'h000;
                tx_cnt_r <= char_bits(nine);
              end else if (tx_en && !te_flag_r) begin
                tx_sh_r  <= nine ? frame9 : {1'b1, frame8[10:1]};
                tx_cnt_r <= char_bits(nine);
                tx_brk_r <= 1'b0;
              end else begin
                tx_st_r    <= TX_IDLE;
                tx_brk_r   <= 1'b0;
                tx_qidle_r <= 1'b0;
              end
            end
          end
        end
        default: tx_st_r <= TX_IDLE;
      endcase
      if (tx_post_r && tx_st_r == TX_PRE && bit_end)
        tx_post_r <= 1'b0;
    end
  end

  wire tx_load = en && bit_end && last && !brk && tx_en && !te_flag_r &&
                 ((tx_st_r == TX_PRE) ||
                  (tx_st_r == TX_SHFT && !(tx_brk_r && !brk) &&
                   !tx_qidle_r));

  // ---------------------------------------------------------------
  // Receiver input synchroniser and sampling
  // ---------------------------------------------------------------
  localparam RX_HUNT = 3'b001;
  localparam RX_STRT = 3'b010;
  localparam RX_DATA = 3'b100;

  reg [2:0]  rx_sync_r;
  reg        rx_in_r;
  reg [2:0]  rx_hist_r;
  reg [2:0]  rx_st_r;
  reg [3:0]  rx_rt_r;
  reg [2:0]  rx_smp_r;
  reg [3:0]  rx_cnt_r;
  reg [9:0]  rx_sh_r;
  reg        rx_noise_r;
  reg        rx_prev_r;

  wire rx_bit  = maj3(rx_smp_r);
  wire rx_dis  = (rx_smp_r != 3'h0) && (rx_smp_r != 3'h7);
  wire [3:0] rx_total = char_bits(nine) - 4'h2;
  wire rd_st1  = reg_rd && (reg_addr == `ASC_STAT1);
  wire rd_dat  = reg_rd && (reg_addr == `ASC_DATA);
  reg  rx_done;
  reg  rx_fe;
  reg  rx_brk;

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_sync_r <= 3'h7;
      rx_in_r   <= 1'b1;
    end else begin
      rx_sync_r <= {rx_sync_r[1:0], serial_in_pin};
      if (rx_sync_r[1] == rx_sync_r[2])
        rx_in_r <= rx_sync_r[2];
    end
  end

  always @* begin
    rx_done = 1'b0;
    rx_fe   = 1'b0;
    rx_brk  = 1'b0;
    if (rx_st_r == RX_DATA && rt_tick && rx_rt_r == `ASC_RT_LAST &&
        rx_cnt_r == rx_total) begin
      rx_done = 1'b1;
      rx_fe   = !rx_bit;
      rx_brk  = !rx_bit && (rx_sh_r == 10'h000);
    end
  end

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_st_r    <= RX_HUNT;
      rx_hist_r  <= 3'h0;
      rx_rt_r    <= 4'h0;
      rx_smp_r   <= 3'h0;
      rx_cnt_r   <= 4'h0;
      rx_sh_r    <= 10'h000;
      rx_noise_r <= 1'b0;
      rx_prev_r  <= 1'b1;
    end else if (!en || !rx_en) begin
      rx_st_r   <= RX_HUNT;
      rx_hist_r <= 3'h0;
    end else if (rt_tick) begin
      rx_rt_r <= rx_rt_r + 4'h1;
      case (rx_st_r)
        RX_HUNT: begin
          rx_hist_r <= {rx_hist_r[1:0], rx_in_r};
          if (rx_hist_r == 3'h7 && !rx_in_r) begin
            rx_st_r    <= RX_STRT;
            rx_rt_r    <= 4'h2;
            rx_sh_r    <= 10'h000;
            rx_noise_r <= 1'b0;
            rx_smp_r   <= 3'h0;
          end
        end
        RX_STRT: begin
          if (rx_rt_r == 4'h3 || rx_rt_r == 4'h5 || rx_rt_r == 4'h7)
            rx_smp_r <= {rx_smp_r[1:0], rx_in_r};
          if (rx_rt_r == 4'h8) begin
            if (rx_bit) begin
              rx_st_r   <= RX_HUNT;
              rx_hist_r <= 3'h0;
            end else begin
              rx_noise_r <= rx_dis;
              rx_smp_r   <= {2'h0, rx_in_r};
            end
          end
          if (rx_rt_r == 4'h9 || rx_rt_r == 4'ha)
            rx_smp_r <= {rx_smp_r[1:0], rx_in_r};
          if (rx_rt_r == `ASC_RT_LAST) begin
            rx_noise_r <= rx_noise_r | rx_dis;
            rx_st_r    <= RX_DATA;
            rx_rt_r    <= 4'h0;
            rx_cnt_r   <= 4'h0;
            rx_prev_r  <= 1'b0;
          end
        end
        RX_DATA: begin
          if (rx_rt_r >= 4'h8 && rx_rt_r <= 4'ha)
            rx_smp_r <= {rx_smp_r[1:0], rx_in_r};
          if (rx_rt_r == `ASC_RT_LAST) begin
            rx_noise_r <= rx_noise_r | rx_dis;
            rx_prev_r  <= rx_bit;
            rx_cnt_r   <= rx_cnt_r + 4'h1;
            if (rx_cnt_r != rx_total)
              rx_sh_r <= {rx_bit, rx_sh_r[9:1]};
            else
              rx_st_r <= RX_HUNT;
          end
          if (rx_prev_r && rx_in_r == 1'b0 && rx_hist_r[0] &&
              rx_rt_r < 4'h4)
            rx_rt_r <= 4'h2;
          rx_hist_r <= {rx_hist_r[1:0], rx_in_r};
        end
        default: rx_st_r <= RX_HUNT;
      endcase
    end
  end

  // Received payload aligned for the chosen length.
  wire [8:0] rx_word = nine ? rx_sh_r[9:1] : {rx_sh_r[9], rx_sh_r[9:2]};
  wire       rpar    = ^{rx_word[7:0], nine & rx_word[8]} ^
                       ctrl1_r[`C1_PAR_ODD];

  // ---------------------------------------------------------------
  // Register writes and flags
  // ---------------------------------------------------------------
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl1_r      <= 8'h00;
      ctrl2_r      <= 8'h00;
      tx9_r        <= 1'b0;
      rx9_r        <= 1'b0;
      baud_r       <= `ASC_BAUD_RST;
      tdata_r      <= 8'h00;
      rdata_r      <= 8'h00;
      te_flag_r    <= 1'b1;
      tc_flag_r    <= 1'b1;
      rf_flag_r    <= 1'b0;
      or_flag_r    <= 1'b0;
      nf_flag_r    <= 1'b0;
      fe_flag_r    <= 1'b0;
      pe_flag_r    <= 1'b0;
      bk_flag_r    <= 1'b0;
      rp_flag_r    <= 1'b0;
      stat1_seen_r <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == `ASC_CTRL1)
        ctrl1_r <= reg_wdata;
      if (wr_c2)
        ctrl2_r <= reg_wdata;
      if (reg_wr && reg_addr == `ASC_CTRL3)
        tx9_r <= reg_wdata[`C3_TX9];
      if (reg_wr && reg_addr == `ASC_BAUD)
        baud_r <= reg_wdata;
      if (rd_st1)
        stat1_seen_r <= 1'b1;
      if (wr_data) begin
        tdata_r <= reg_wdata;
        if (stat1_seen_r)
          te_flag_r <= 1'b0;
        stat1_seen_r <= 1'b0;
      end
      if (tx_load)
        te_flag_r <= 1'b1;
      tc_flag_r <= te_flag_r && !wr_data && tx_st_r == TX_IDLE &&
                   !brk;
      rp_flag_r <= rx_st_r != RX_HUNT;
      if (rd_dat && rf_flag_r && stat1_seen_r) begin
        rf_flag_r <= 1'b0;
        or_flag_r <= 1'b0;
        nf_flag_r <= 1'b0;
        fe_flag_r <= 1'b0;
        pe_flag_r <= 1'b0;
        bk_flag_r <= 1'b0;
        stat1_seen_r <= 1'b0;
      end
      if (rx_done) begin
        if (rf_flag_r)
          or_flag_r <= 1'b1;
        else begin
          rf_flag_r <= 1'b1;
          rdata_r   <= rx_brk ? 8'h00 : rx_word[7:0];
          rx9_r     <= rx_brk ? 1'b0 : (nine ? rx_word[8] :
                                         rx_word[7]);
        end
        fe_flag_r <= rx_fe;
        nf_flag_r <= rx_noise_r | rx_dis;
        pe_flag_r <= par_en && rpar && !rx_brk;
        if (rx_brk)
          bk_flag_r <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Read port and outputs
  // ---------------------------------------------------------------
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata      <= 8'h00;
      serial_out_pin <= 1'b1;
      serial_out_oe  <= 1'b0;
      tx_irq         <= 1'b0;
      rx_irq         <= 1'b0;
    end else begin
      reg_rdata <= 8'h00;
      if (reg_rd) begin
        case (reg_addr)
          `ASC_CTRL1: reg_rdata <= ctrl1_r;
          `ASC_CTRL2: reg_rdata <= ctrl2_r;
          `ASC_CTRL3: reg_rdata <= {rx9_r, tx9_r, 6'h00};
          `ASC_STAT1: reg_rdata <= {te_flag_r, tc_flag_r, rf_flag_r,
                                    1'b0, or_flag_r, nf_flag_r,
                                    fe_flag_r, pe_flag_r};
          `ASC_STAT2: reg_rdata <= {6'h00, bk_flag_r, rp_flag_r};
          `ASC_DATA:  reg_rdata <= rdata_r;
          `ASC_BAUD:  reg_rdata <= baud_r;
          default:    reg_rdata <= 8'h00;
        endcase
      end
      serial_out_pin <= tx_line_r ^ ctrl1_r[`C1_INVERT];
      serial_out_oe  <= en && (tx_en || tx_st_r != TX_IDLE);
      tx_irq <= (te_flag_r && ctrl2_r[`C2_TE_IE]) ||
                (tc_flag_r && ctrl2_r[`C2_TC_IE]);
      rx_irq <= rf_flag_r && ctrl2_r[`C2_RF_IE];
    end
  end

endmodule

// ---- design/asc_regs.vh ----
// Register offsets, field positions, reset values and timing counts.
// Summary of operation
// - Send 8 or 9 bits; tx ninth bit.
// - Rx ninth bit gets bit 8 or 7.
// - Preamble of ones precedes first data load.
// - Start bit zero first, stop bit one last.
// - Set tx empty on buffer handoff; interrupt.
// - Idle shifter drives line high.
// - Module disable releases both pins.
// - Send break repeats all-zero characters.
// - After break ends, send at least one one; a break begun while data shifts lets a waiting character follow at once.
// - All-zero character with zero stop is break.
// - Break sets flags, clears data and ninth bit.
// - Idle character all ones, starts every transmission.
// - Tx disable finishes character; toggle queues idle.
// - Inversion bit inverts every transmitted level.
// - Tx complete when all empty and idle.
// - Full character moves to buffer, sets rx full.
// - Receiver samples at sixteen times baud.
// - Resync sample clock on start and on a data falling edge.
// - Start search: zero after three ones.
// - Verify start with samples three, five, seven.
// - Two ones of three fail start verification.
// - Data bit is majority; disagreement sets noise.
// - Missing stop one sets framing error.
`ifndef ASC_REGS_VH
`define ASC_REGS_VH
// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define ASC_CTRL1     3'h0
`define ASC_CTRL2     3'h1
`define ASC_CTRL3     3'h2
`define ASC_STAT1     3'h3
`define ASC_STAT2     3'h4
`define ASC_DATA      3'h5
`define ASC_BAUD      3'h6
// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define C1_ENABLE     6
`define C1_INVERT     5
`define C1_NINE       4
`define C1_PAR_EN     1
`define C1_PAR_ODD    0
`define C2_TE_IE      7
`define C2_TC_IE      6
`define C2_RF_IE      5
`define C2_TX_EN      3
`define C2_RX_EN      2
`define C2_BREAK      0
`define C3_RX9        7
`define C3_TX9        6
// ---------------------------------------------------------------
// Reset values and timing
// ---------------------------------------------------------------
`define ASC_STAT1_RST 8'hc0
`define ASC_BAUD_RST  8'h00
`define ASC_RT_LAST   4'hf
`endif

// ---- test/asc_core_monitor.sv ----
// Port-level assertions for the serial core.
`timescale 1ns/100ps
module asc_core_monitor #(
  parameter DIVW = 8
) (
  // Clock and reset
  input wire       core_clk,
  input wire       rst_n,
  // Register port
  input wire [2:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire       reg_wr,
  input wire       reg_rd,
  input wire [7:0] reg_rdata,
  // Serial pins
  input wire       serial_in_pin,
  input wire       serial_out_pin,
  input wire       serial_out_oe,
  // Interrupt requests
  input wire       tx_irq,
  input wire       rx_irq
);
  // ---------------------------------------------------------------
  // Shadow of the control bits and run length of the output line
  // ---------------------------------------------------------------
  logic        en_s, inv_s, te_s, teie_s, tx_complete_irq_en_s, rfie_s, baud0_s;
  logic        clean_r, line_q;
  logic [3:0]  quiet_r;
  logic [11:0] run_r;
  wire ctl1_wr = reg_wr && reg_addr == 3'h0;
  wire ctl2_wr = reg_wr && reg_addr == 3'h1;
  wire baud_wr = reg_wr && reg_addr == 3'h6;
  wire zero_end = (serial_out_pin ^ inv_s) && !(line_q ^ inv_s);

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      {en_s, inv_s, te_s, teie_s, tx_complete_irq_en_s, rfie_s} <= 6'h00;
      baud0_s <= 1'h1;
      clean_r <= 1'h0;
      line_q  <= 1'h1;
      quiet_r <= 4'h0;
      run_r   <= 12'h000;
    end else begin
      line_q <= serial_out_pin;
      if (ctl1_wr) begin
        en_s  <= reg_wdata[6];
        inv_s <= reg_wdata[5];
      end
      if (ctl2_wr) begin
        {teie_s, tx_complete_irq_en_s, rfie_s} <= reg_wdata[7:5];
        te_s <= reg_wdata[3];
      end
      if (baud_wr) begin
        baud0_s <= reg_wdata == 8'h00;
      end
      if (ctl1_wr) begin
        quiet_r <= 4'h0;
      end else if (quiet_r != 4'hf) begin
        quiet_r <= quiet_r + 4'h1;
      end
      if (serial_out_pin != line_q) begin
        run_r   <= 12'h001;
        clean_r <= !(ctl1_wr || baud_wr);
      end else begin
        if (run_r != 12'hfff) begin
          run_r <= run_r + 12'h001;
        end
        if (ctl1_wr || baud_wr) begin
          clean_r <= 1'h0;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence s_enable_off;
    ctl1_wr && !reg_wdata[6];
  endsequence
  sequence s_oe_low_held;
    !serial_out_oe [*2];
  endsequence

  property p_release;
    s_enable_off |-> ##[1:3] s_oe_low_held;
  endproperty
  a_release: assert property (p_release)
    else $error("output enable kept after module disable");
  property p_oe_on;
    (en_s && te_s) [*3] |-> serial_out_oe;
  endproperty
  a_oe_on: assert property (p_oe_on)
    else $error("output enable low while enabled");
  property p_idle_level;
    (quiet_r >= 4'h3 && !en_s) |-> serial_out_pin == !inv_s;
  endproperty
  a_idle_level: assert property (p_idle_level)
    else $error("disabled line not at idle level");
  property p_rdata_quiet;
    !$past(reg_rd) |-> reg_rdata == 8'h00;
  endproperty
  a_rdata_quiet: assert property (p_rdata_quiet)
    else $error("read data outside the answer cycle");
  property p_unmapped;
    reg_rd && reg_addr == 3'h7 |=> reg_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped index read nonzero");
  property p_rx_irq_mask;
    !rfie_s [*2] |-> !rx_irq;
  endproperty
  a_rx_irq_mask: assert property (p_rx_irq_mask)
    else $error("receive request while masked");
  property p_tx_irq_mask;
    (!teie_s && !tx_complete_irq_en_s) [*2] |-> !tx_irq;
  endproperty
  a_tx_irq_mask: assert property (p_tx_irq_mask)
    else $error("transmit request while masked");
  property p_zero_run;
    zero_end && clean_r && baud0_s && en_s && serial_out_oe
      |-> run_r[3:0] == 4'h0;
  endproperty
  a_zero_run: assert property (p_zero_run)
    else $error("low run not a whole number of bit times");
endmodule

bind asc_core asc_core_monitor #(.DIVW(DIVW)) mon_u (
  .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .serial_in_pin(serial_in_pin),
  .serial_out_pin(serial_out_pin), .serial_out_oe(serial_out_oe),
  .tx_irq(tx_irq), .rx_irq(rx_irq));

// ---- test/asc_remote_dev.sv ----
// Behavioural remote serial device facing the core's pins.
`timescale 1ns/100ps
module asc_remote_dev (
  // Clock
  input  wire  core_clk,
  // Line from the core
  input  wire  tx_line,
  input  wire  tx_oe,
  // Frame settings
  input  wire  inv,
  input  wire  nine,
  // Line to the core
  output logic rx_line
);
  logic [8:0] got_data;
  logic       got_stop;
  logic       busy;
  int         i;

  initial begin
    rx_line  = 1'h1;
    busy     = 1'h0;
    got_data = 9'h000;
    got_stop = 1'h0;
  end

  // Start on a low level, then sample each bit at its middle.
  initial begin
    forever begin
      @(posedge core_clk);
      if (tx_oe && !(tx_line ^ inv)) begin
        busy = 1'h1;
        got_data = 9'h000;
        repeat (8) @(posedge core_clk);
        for (i = 0; i < (nine ? 9 : 8); i++) begin
          repeat (16) @(posedge core_clk);
          got_data[i] = tx_line ^ inv;
        end
        repeat (16) @(posedge core_clk);
        got_stop = tx_line ^ inv;
        while (!(tx_line ^ inv)) @(posedge core_clk);
        busy = 1'h0;
      end
    end
  end

  // Sends start, data LSB first, stop, then idle: one bit time for nine bits, two for eight.
  task automatic send(input logic [8:0] d, input logic stop,
                      input logic n9);
    logic [11:0] f;
    int k;
    f = n9 ? {1'h1, stop, d, 1'h0} : {2'h3, stop, d[7:0], 1'h0};
    for (k = 0; k < 12; k++) begin
      @(posedge core_clk);
      rx_line <= f[k];
      repeat (15) @(posedge core_clk);
    end
  endtask
endmodule

// ---- test/asc_core_tb.sv ----
// Self-checking testbench for the serial core.
`timescale 1ns/100ps
`include "asc_regs.vh"
module asc_core_tb;
  logic       core_clk, rst_n, reg_wr, reg_rd, p_inv, p_nine;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata, v;
  wire  [7:0] reg_rdata;
  wire        serial_in_pin, serial_out_pin, serial_out_oe;
  wire        tx_irq, rx_irq, tx_wire;
  int         n_fail, n_checks;

  assign tx_wire = serial_out_oe ? serial_out_pin : 1'h1;

  asc_core #(.DIVW(8)) dut_u (
    .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .serial_in_pin(serial_in_pin),
    .serial_out_pin(serial_out_pin), .serial_out_oe(serial_out_oe),
    .tx_irq(tx_irq), .rx_irq(rx_irq));
  asc_remote_dev peer_u (
    .core_clk(core_clk), .tx_line(tx_wire), .tx_oe(serial_out_oe),
    .inv(p_inv), .nine(p_nine), .rx_line(serial_in_pin));

  always #20 core_clk = ~core_clk;

  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic results;
    $display("Checks %0d, mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'h0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'h0;
    #1 d = reg_rdata;
  endtask
  function automatic logic done(input int sel);
    case (sel)
      0: return peer_u.busy === 1'h1;
      1: return rx_irq === 1'h1;
      default: return peer_u.busy === 1'h0;
    endcase
  endfunction
  task automatic wait_for(input int sel, input int lim, output int n);
    for (n = 0; !done(sel); n++) begin
      if (n == lim) begin
        n_fail++;
        $display("MISMATCH t=%0t wait %0d timed out", $time, sel);
        results();
      end
      @(posedge core_clk);
    end
  endtask

  task automatic tx_frame(input logic nine, input logic inv,
                          input logic [8:0] d);
    int n;
    p_nine = nine;
    p_inv = inv;
    wr(`ASC_CTRL1, {2'h1, inv, nine, 4'h0});
    wr(`ASC_CTRL3, {1'h0, d[8], 6'h00});
    wr(`ASC_CTRL2, 8'h08);
    rd(`ASC_STAT1, v);
    wr(`ASC_DATA, d[7:0]);
    wait_for(0, 600, n);
    check(9'(n >= (nine ? 168 : 152)), 9'h001);
    wait_for(2, 400, n);
    check(peer_u.got_data, nine ? d : {1'h0, d[7:0]});
    check(peer_u.got_stop, 1'h1);
    repeat (40) @(posedge core_clk);
    rd(`ASC_STAT1, v);
    check(v[7:6], 2'h3);
    wr(`ASC_CTRL2, 8'h88);
    repeat (3) @(posedge core_clk);
    check(tx_irq, 1'h1);
    wr(`ASC_CTRL2, 8'h48);
    repeat (3) @(posedge core_clk);
    check(tx_irq, 1'h1);
    wr(`ASC_CTRL2, 8'h00);
    wr(`ASC_CTRL1, 8'h00);
  endtask

  task automatic tx_break;
    int n;
    p_nine = 1'h0;
    p_inv = 1'h0;
    wr(`ASC_CTRL1, 8'h40);
    wr(`ASC_CTRL2, 8'h09);
    wait_for(0, 600, n);
    repeat (300) @(posedge core_clk);
    wr(`ASC_CTRL2, 8'h08);
    wait_for(2, 600, n);
    check(peer_u.got_data, 9'h000);
    check(peer_u.got_stop, 1'h0);
    for (n = 0; n < 16; n++) begin
      check(tx_wire, 1'h1);
      @(posedge core_clk);
    end
    rd(`ASC_STAT1, v);
    wr(`ASC_DATA, 8'h5e);
    wait_for(0, 600, n);
    wr(`ASC_CTRL2, 8'h00);
    wait_for(2, 400, n);
    check(peer_u.got_data, 9'h05e);
    check(peer_u.got_stop, 1'h1);
    wr(`ASC_CTRL2, 8'h08);
    rd(`ASC_STAT1, v);
    wr(`ASC_DATA, 8'h33);
    wait_for(0, 600, n);
    wr(`ASC_CTRL2, 8'h00);
    wr(`ASC_CTRL2, 8'h08);
    rd(`ASC_STAT1, v);
    wr(`ASC_DATA, 8'h66);
    wait_for(2, 400, n);
    check(peer_u.got_data, 9'h033);
    wait_for(0, 600, n);
    check(9'(n >= 152), 9'h001);
    wait_for(2, 400, n);
    check(peer_u.got_data, 9'h066);
    rd(`ASC_STAT1, v);
    wr(`ASC_DATA, 8'ha1);
    wait_for(0, 600, n);
    wr(`ASC_CTRL1, 8'h00);
    repeat (3) @(posedge core_clk);
    check(serial_out_oe, 1'h0);
    wait_for(2, 400, n);
    wr(`ASC_CTRL2, 8'h00);
  endtask

  task automatic rx_frame(input logic nine, input logic [8:0] d,
                          input logic stop);
    int n;
    logic brk;
    brk = (nine ? d : {1'h0, d[7:0]}) == 9'h000 && !stop;
    wr(`ASC_CTRL1, {3'h2, nine, 4'h0});
    wr(`ASC_CTRL2, 8'h24);
    peer_u.send(d, stop, nine);
    wait_for(1, 200, n);
    rd(`ASC_STAT1, v);
    check(v[5], 1'h1);
    check(v[1], !stop);
    rd(`ASC_STAT2, v);
    check(v[1], brk);
    rd(`ASC_DATA, v);
    check(v, brk ? 8'h00 : d[7:0]);
    rd(`ASC_CTRL3, v);
    check(v[7], brk ? 1'h0 : nine ? d[8] : d[7]);
    repeat (2) @(posedge core_clk);
    check(rx_irq, 1'h0);
    wr(`ASC_CTRL2, 8'h00);
    wr(`ASC_CTRL1, 8'h00);
  endtask

  initial begin
    core_clk = 1'h0;
    rst_n = 1'h0;
    {reg_wr, reg_rd, p_inv, p_nine} = 4'h0;
    reg_addr = 3'h0;
    reg_wdata = 8'h00;
    n_fail = 0;
    n_checks = 0;
    repeat (8) @(posedge core_clk);
    rst_n <= 1'h1;
    rd(`ASC_STAT1, v);
    check(v, `ASC_STAT1_RST);
    wr(3'h7, 8'hff);
    rd(3'h7, v);
    check(v, 8'h00);
    rd(`ASC_BAUD, v);
    check(v, `ASC_BAUD_RST);
    tx_frame(1'h0, 1'h0, 9'h0a5);
    tx_frame(1'h1, 1'h0, 9'h13c);
    tx_frame(1'h1, 1'h1, 9'h0c3);
    tx_frame(1'h0, 1'h1, 9'h05a);
    tx_break();
    rx_frame(1'h0, 9'h096, 1'h1);
    rx_frame(1'h1, 9'h15a, 1'h1);
    rx_frame(1'h0, 9'h03c, 1'h0);
    rx_frame(1'h1, 9'h000, 1'h0);
    results();
  end
endmodule
